// >>> pis_defines.svh
// Function
// R1: master waits powerup_read_delay before reads
// R2: master waits powerup_write_delay before writes
// R3: wiper tap follows recalled setting within 5-10us
// R4: wiper tap settles 5-10us after change
// R5: nonvolatile write ends within 5ms after STOP
// R6: busy device releases data line, no ack
// R7: master starts only on idle bus, clocks
// R8: data stable while clock high, else START/STOP
// R9: device ignores bus until START
// R10: master ends every operation with STOP
// R11: receiver acks during ninth clock
// R12: ack own address, then every written byte
// R13: read: send byte, continue only if acked
// R14: ack polling: no ack while busy
// R15: selector loaded by 3-byte write, 02h
// R16: type field plus two strap bits match
// R17: lsb 1 read, 0 write; selector write-only
// R18: wiper keeps 7 bits, msb reads zero
// R19: target written with 00h then data byte
// R20: stored write also updates wiper register
// R21: START mid-transfer restarts address decoding
`ifndef PIS_DEFINES_SVH
`define PIS_DEFINES_SVH

// ************************************************
// register addresses on the serial link
// ************************************************
`define PIS_SEL_ADDR 8'h02
`define PIS_DATA_ADDR 8'h00
`define PIS_SEL_WIPER 8'h80
`define PIS_SEL_STORED 8'h00
`define PIS_SEL_RESET 8'h80
`define PIS_WIPER_MID 7'h40

// ************************************************
// timing
// ************************************************
`define PIS_CLK_MHZ 250
`define PIS_SETTLE_US 5
`define PIS_SETTLE_CYC (`PIS_SETTLE_US * `PIS_CLK_MHZ)
`define PIS_NV_PROGRAM_MS 5
`define PIS_NV_PROGRAM_CYC (`PIS_NV_PROGRAM_MS * 1000 * `PIS_CLK_MHZ)
`define PIS_POWERUP_MS 1
`define PIS_POWERUP_CYC (`PIS_POWERUP_MS * 1000 * `PIS_CLK_MHZ)

// ************************************************
// controller registers (apb byte offsets)
// ************************************************
`define PIS_REG_CMD 12'h000
`define PIS_REG_STATUS 12'h004
`define PIS_REG_DIV 12'h008
`define PIS_CMD_START 8
`define PIS_CMD_STOP 9
`define PIS_CMD_READ 10
`define PIS_CMD_NACK 11
`define PIS_ST_BUSY 0
`define PIS_ST_NACK 1
`define PIS_ST_READY 2
`define PIS_ST_HELD 3
`define PIS_ST_RX 8
`define PIS_DIV_RESET 16'h0008

`endif

// >>> pis_pkg.sv
package pis_pkg;
  typedef enum logic [2:0] {
    D_IDLE, D_ADDR, D_AACK, D_RX, D_RACK, D_TX, D_MACK, D_WAIT
  } pis_dev_state_t;
  typedef enum logic [1:0] {
    H_IDLE, H_START, H_BIT, H_STOP
  } pis_host_state_t;
endpackage

// >>> pis_if.sv
`timescale 1ns/10ps
interface pis_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // ************************************************
  // open-drain wired and with pull-up
  // ************************************************
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (
    input scl, input sda,
    output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe
  );
endinterface

// >>> pis_device.sv
`timescale 1ns/10ps
`include "pis_defines.svh"
module pis_device import pis_pkg::*; #(
  // arbitrary device type value
  parameter logic [4:0] TYPE_ID = 5'h0c,
  parameter int NV_CYC = `PIS_NV_PROGRAM_CYC,
  parameter logic [6:0] STORED_INIT = `PIS_WIPER_MID
) (
  // system
  input wire logic pclk,
  input wire logic presetn,
  // serial bus
  pis_if.dev bus,
  // straps
  input wire logic strap_addr_hi,
  input wire logic strap_addr_lo,
  // potentiometer state
  output logic [6:0] wiper_tap,
  output logic [6:0] wiper_setting_reg,
  output logic [6:0] stored_setting_reg,
  output logic [7:0] register_selector,
  output logic nv_busy
);
  localparam int NVW = $clog2(NV_CYC + 1);
  localparam int STW = $clog2(`PIS_SETTLE_CYC + 1);

  // ************************************************
  // input synchronisers
  // ************************************************
  logic [3:0] raw;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] filt_q;
  assign raw = {bus.scl, bus.sda, strap_addr_hi, strap_addr_lo};

  for (genvar gi = 0; gi < 4; gi++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_q[gi] <= 1'b1;
        s2_q[gi] <= 1'b1;
        s3_q[gi] <= 1'b1;
        filt_q[gi] <= 1'b1;
      end else begin
        s1_q[gi] <= raw[gi];
        s2_q[gi] <= s1_q[gi];
        s3_q[gi] <= s2_q[gi];
        if (s2_q[gi] == s3_q[gi]) begin
          filt_q[gi] <= s3_q[gi];
        end
      end
    end
  end

  logic scl_f;
  logic sda_f;
  logic scl_prev_q;
  logic sda_prev_q;
  assign scl_f = filt_q[3];
  assign sda_f = filt_q[2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_f;
      sda_prev_q <= sda_f;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise = scl_f & ~scl_prev_q;
  assign scl_fall = ~scl_f & scl_prev_q;
  // data edges while clock high are bus conditions
  assign start_det = scl_f & scl_prev_q & sda_prev_q & ~sda_f; // R8
  assign stop_det = scl_f & scl_prev_q & ~sda_prev_q & sda_f; // R8

  // ************************************************
  // byte engine
  // ************************************************
  pis_dev_state_t st_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [1:0] idx_q;
  logic rd_q;
  logic mack_q;
  logic [7:0] regaddr_q;
  logic [6:0] nv_data_q;
  logic nv_pend_q;
  logic [NVW-1:0] nv_cnt_q;
  logic [7:0] rd_byte;
  logic addr_hit;
  logic byte_done;

  // msb of every read is zero, selector never reads back
  assign rd_byte = {1'b0, (register_selector == `PIS_SEL_WIPER) ?
                    wiper_setting_reg : stored_setting_reg}; // R18 R17
  assign addr_hit = (sh_q[7:3] == TYPE_ID) &&
                    (sh_q[2:1] == {filt_q[1], filt_q[0]}); // R16
  assign byte_done = (st_q == D_RX) && scl_fall && (cnt_q == 4'h8) &&
                     !nv_busy && !start_det && !stop_det;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= D_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      idx_q <= 2'h0;
      rd_q <= 1'b0;
      mack_q <= 1'b0;
      bus.dev_sda_oe <= 1'b0;
      bus.dev_sda_o <= 1'b0;
    end else if (nv_busy) begin
      // deaf during programming, line released
      st_q <= D_IDLE; // R6 R14
      bus.dev_sda_oe <= 1'b0; // R6
    end else if (start_det) begin
      st_q <= D_ADDR; // R9 R21
      cnt_q <= 4'h0; // R21
      idx_q <= 2'h0;
      bus.dev_sda_oe <= 1'b0;
    end else if (stop_det) begin
      st_q <= D_IDLE;
      bus.dev_sda_oe <= 1'b0;
    end else begin
      case (st_q)
        D_IDLE: begin
          bus.dev_sda_oe <= 1'b0; // R9
        end
        D_ADDR, D_RX: begin
          if (scl_rise && cnt_q != 4'h8) begin
            sh_q <= {sh_q[6:0], sda_f};
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            if (st_q == D_RX) begin
              bus.dev_sda_oe <= 1'b1; // R11 R12
              st_q <= D_RACK;
              if (idx_q != 2'h2) begin
                idx_q <= idx_q + 2'h1;
              end
            end else if (addr_hit) begin
              bus.dev_sda_oe <= 1'b1; // R11 R12
              rd_q <= sh_q[0]; // R17
              st_q <= D_AACK;
            end else begin
              st_q <= D_WAIT;
            end
          end
        end
        D_AACK: begin
          if (scl_fall) begin
            cnt_q <= 4'h0;
            if (rd_q) begin
              sh_q <= rd_byte;
              bus.dev_sda_oe <= ~rd_byte[7];
              st_q <= D_TX;
            end else begin
              bus.dev_sda_oe <= 1'b0;
              st_q <= D_RX;
            end
          end
        end
        D_RACK: begin
          if (scl_fall) begin
            bus.dev_sda_oe <= 1'b0;
            cnt_q <= 4'h0;
            st_q <= D_RX;
          end
        end
        D_TX: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            bus.dev_sda_oe <= 1'b0; // R13
            st_q <= D_MACK;
          end else if (scl_fall && cnt_q != 4'h0) begin
            sh_q <= {sh_q[6:0], 1'b0};
            bus.dev_sda_oe <= ~sh_q[6];
          end
        end
        D_MACK: begin
          if (scl_rise) begin
            mack_q <= ~sda_f; // R11
          end else if (scl_fall) begin
            cnt_q <= 4'h0;
            if (mack_q) begin
              sh_q <= rd_byte; // R13
              bus.dev_sda_oe <= ~rd_byte[7];
              st_q <= D_TX;
            end else begin
              st_q <= D_WAIT; // R13
            end
          end
        end
        D_WAIT: begin
          bus.dev_sda_oe <= 1'b0;
        end
        default: begin
          st_q <= D_IDLE;
        end
      endcase
    end
  end

  // ************************************************
  // registers and nonvolatile write cycle
  // ************************************************
  logic recall_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wiper_setting_reg <= `PIS_WIPER_MID;
      stored_setting_reg <= STORED_INIT;
      register_selector <= `PIS_SEL_RESET;
      regaddr_q <= 8'h00;
      nv_data_q <= 7'h00;
      nv_pend_q <= 1'b0;
      nv_busy <= 1'b0;
      nv_cnt_q <= '0;
      recall_q <= 1'b1;
    end else begin
      if (recall_q) begin
        wiper_setting_reg <= stored_setting_reg; // R3
        recall_q <= 1'b0;
      end
      if (byte_done && idx_q == 2'h0) begin
        regaddr_q <= sh_q;
      end
      if (byte_done && idx_q == 2'h1) begin
        if (regaddr_q == `PIS_SEL_ADDR) begin
          register_selector <= sh_q; // R15
        end else if (regaddr_q == `PIS_DATA_ADDR) begin
          if (register_selector == `PIS_SEL_WIPER) begin
            wiper_setting_reg <= sh_q[6:0]; // R18
          end else begin
            nv_data_q <= sh_q[6:0]; // R18
            nv_pend_q <= 1'b1;
          end
        end
      end
      if (stop_det && nv_pend_q && !nv_busy) begin
        nv_busy <= 1'b1; // R5
        nv_pend_q <= 1'b0;
        nv_cnt_q <= '0;
      end else if (start_det) begin
        nv_pend_q <= 1'b0;
      end
      if (nv_busy) begin
        nv_cnt_q <= nv_cnt_q + NVW'(1);
        if (nv_cnt_q == NVW'(NV_CYC - 1)) begin
          nv_busy <= 1'b0; // R5 R14
          stored_setting_reg <= nv_data_q;
          wiper_setting_reg <= nv_data_q; // R20
        end
      end
    end
  end

  // ************************************************
  // wiper settling
  // ************************************************
  logic [6:0] last_q;
  logic settle_q;
  logic [STW-1:0] settle_cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wiper_tap <= `PIS_WIPER_MID;
      last_q <= `PIS_WIPER_MID;
      settle_q <= 1'b1;
      settle_cnt_q <= '0;
    end else if (wiper_setting_reg != last_q) begin
      last_q <= wiper_setting_reg;
      settle_q <= 1'b1; // R4
      settle_cnt_q <= '0;
    end else if (settle_q) begin
      if (settle_cnt_q == STW'(`PIS_SETTLE_CYC - 1)) begin
        wiper_tap <= wiper_setting_reg; // R3 R4
        settle_q <= 1'b0;
      end else begin
        settle_cnt_q <= settle_cnt_q + STW'(1);
      end
    end
  end
endmodule

// >>> pis_host.sv
`timescale 1ns/10ps
`include "pis_defines.svh"
module pis_host import pis_pkg::*; #(
  parameter int POWERUP_CYC = `PIS_POWERUP_CYC
) (
  // system
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial bus
  pis_if.host bus
);
  localparam int PUW = $clog2(POWERUP_CYC + 1);

  // ************************************************
  // line synchronisers
  // ************************************************
  logic [1:0] raw;
  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic [1:0] s3_q;
  logic [1:0] filt_q;
  assign raw = {bus.scl, bus.sda};

  for (genvar gi = 0; gi < 2; gi++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_q[gi] <= 1'b1;
        s2_q[gi] <= 1'b1;
        s3_q[gi] <= 1'b1;
        filt_q[gi] <= 1'b1;
      end else begin
        s1_q[gi] <= raw[gi];
        s2_q[gi] <= s1_q[gi];
        s3_q[gi] <= s2_q[gi];
        if (s2_q[gi] == s3_q[gi]) begin
          filt_q[gi] <= s3_q[gi];
        end
      end
    end
  end

  // ************************************************
  // power-up hold-off
  // ************************************************
  logic [PUW-1:0] pu_cnt_q;
  logic pu_done_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pu_cnt_q <= '0;
      pu_done_q <= 1'b0;
    end else if (!pu_done_q) begin
      pu_cnt_q <= pu_cnt_q + PUW'(1);
      pu_done_q <= (pu_cnt_q == PUW'(POWERUP_CYC - 1)); // R1 R2
    end
  end

  // ************************************************
  // apb registers
  // ************************************************
  logic [15:0] div_q;
  logic [11:0] cmd_q;
  logic go_q;
  logic nack_q;
  logic held_q;
  logic [7:0] rx_q;
  logic done;
  logic wr_cmd;
  logic access;

  assign access = psel & penable & ~pready;
  assign wr_cmd = psel & penable & pready & pwrite & (paddr == `PIS_REG_CMD);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      div_q <= `PIS_DIV_RESET;
      cmd_q <= 12'h000;
      go_q <= 1'b0;
    end else begin
      pready <= access;
      pslverr <= access && paddr != `PIS_REG_CMD && paddr != `PIS_REG_STATUS &&
                 paddr != `PIS_REG_DIV;
      if (access) begin
        case (paddr)
          `PIS_REG_CMD: prdata <= {20'h00000, cmd_q};
          `PIS_REG_STATUS: prdata <= {16'h0000, rx_q, 4'h0, held_q, pu_done_q,
                                      nack_q, go_q};
          `PIS_REG_DIV: prdata <= {16'h0000, div_q};
          default: prdata <= 32'h0000_0000;
        endcase
      end
      if (wr_cmd && !go_q) begin
        cmd_q <= pwdata[11:0];
        go_q <= 1'b1;
      end else if (done) begin
        go_q <= 1'b0;
      end
      if (psel && penable && pready && pwrite && paddr == `PIS_REG_DIV && !go_q) begin
        div_q <= pwdata[15:0];
      end
    end
  end

  // ************************************************
  // bit engine: four ticks per bit
  // ************************************************
  pis_host_state_t hst_q;
  logic [1:0] ph_q;
  logic [15:0] tmr_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic tick;
  logic launch;
  logic rd;

  assign tick = (tmr_q >= div_q);
  assign rd = cmd_q[`PIS_CMD_READ];
  // a fresh START needs an idle bus
  assign launch = go_q && pu_done_q && (held_q || (filt_q[1] && filt_q[0])); // R7 R1 R2
  assign done = tick && ph_q == 2'h3 &&
                ((hst_q == H_BIT && bit_q == 4'h8 && !cmd_q[`PIS_CMD_STOP]) ||
                 hst_q == H_STOP);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hst_q <= H_IDLE;
      ph_q <= 2'h0;
      tmr_q <= 16'h0001;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      nack_q <= 1'b0;
      held_q <= 1'b0;
      rx_q <= 8'h00;
      bus.host_scl_oe <= 1'b0;
      bus.host_sda_oe <= 1'b0;
      bus.host_scl_o <= 1'b0;
      bus.host_sda_o <= 1'b0;
    end else if (hst_q == H_IDLE) begin
      tmr_q <= 16'h0001;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      if (launch && !done) begin
        sh_q <= cmd_q[7:0];
        hst_q <= cmd_q[`PIS_CMD_START] ? H_START : H_BIT;
      end
    end else begin
      tmr_q <= tick ? 16'h0001 : tmr_q + 16'h0001;
      if (tick) begin
        ph_q <= ph_q + 2'h1;
        case (hst_q)
          H_START: begin
            case (ph_q)
              2'h0: bus.host_sda_oe <= 1'b0;
              2'h1: bus.host_scl_oe <= 1'b0;
              2'h2: bus.host_sda_oe <= 1'b1; // R8
              default: begin
                bus.host_scl_oe <= 1'b1; // R7
                held_q <= 1'b1;
                hst_q <= H_BIT;
              end
            endcase
          end
          H_BIT: begin
            case (ph_q)
              2'h0: begin
                if (bit_q != 4'h8) begin
                  bus.host_sda_oe <= rd ? 1'b0 : ~sh_q[7];
                end else begin
                  bus.host_sda_oe <= rd ? ~cmd_q[`PIS_CMD_NACK] : 1'b0; // R11
                end
              end
              2'h1: bus.host_scl_oe <= 1'b0;
              2'h2: begin
                if (bit_q != 4'h8) begin
                  sh_q <= {sh_q[6:0], filt_q[0]};
                end else if (!rd) begin
                  nack_q <= filt_q[0]; // R11 R14
                end else begin
                  rx_q <= sh_q;
                end
              end
              default: begin
                bus.host_scl_oe <= 1'b1;
                bit_q <= bit_q + 4'h1;
                if (bit_q == 4'h8) begin
                  hst_q <= cmd_q[`PIS_CMD_STOP] ? H_STOP : H_IDLE;
                end
              end
            endcase
          end
          H_STOP: begin
            case (ph_q)
              2'h0: bus.host_sda_oe <= 1'b1;
              2'h1: bus.host_scl_oe <= 1'b0;
              2'h2: bus.host_sda_oe <= 1'b0; // R10
              default: begin
                held_q <= 1'b0;
                hst_q <= H_IDLE;
              end
            endcase
          end
          default: hst_q <= H_IDLE;
        endcase
      end
    end
  end
endmodule

// >>> pis_props.sv
`timescale 1ns/10ps
module pis_props #(
  parameter int NV_CYC = 1000
) (
  // system
  input wire logic pclk,
  input wire logic presetn,
  // serial bus
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda,
  // device state
  input wire logic nv_busy,
  input wire logic [6:0] wiper_setting_reg,
  input wire logic [6:0] wiper_tap
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ************************************************
  // bus tracking
  // ************************************************
  logic scl_q, sda_q, first_q, seen_q, start_w, stop_w;
  logic [3:0] nbit_q;
  logic [7:0] stop_age_q;
  logic [20:0] busy_cnt_q;
  logic [11:0] set_age_q;
  logic [6:0] set_q;
  assign start_w = scl & scl_q & sda_q & ~sda;
  assign stop_w = scl & scl_q & ~sda_q & sda;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // clock rises since the last start, modulo nine, first byte flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nbit_q <= 4'h0;
      first_q <= 1'b0;
      seen_q <= 1'b0;
    end else if (start_w) begin
      nbit_q <= 4'h0;
      first_q <= 1'b1;
      seen_q <= 1'b1;
    end else if (scl & ~scl_q) begin
      nbit_q <= (nbit_q == 4'h8) ? 4'h0 : nbit_q + 4'h1;
      if (nbit_q == 4'h8) first_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_age_q <= 8'hff;
      busy_cnt_q <= 21'h0;
    end else begin
      stop_age_q <= stop_w ? 8'h0 : (stop_age_q == 8'hff ? 8'hff : stop_age_q + 8'h1);
      busy_cnt_q <= nv_busy ? busy_cnt_q + 21'h1 : 21'h0;
    end
  end

  // cycles since the wiper register last changed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_q <= 7'h40;
      set_age_q <= 12'h0;
    end else begin
      set_q <= wiper_setting_reg;
      if (set_q != wiper_setting_reg) set_age_q <= 12'h0;
      else if (set_age_q != 12'hfff) set_age_q <= set_age_q + 12'h1;
    end
  end

  // ************************************************
  // assertions
  // ************************************************
  a_drain_only: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("device drives data line high");
  a_hold_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device changed data line while clock high");
  a_idle_silent: assert property (!seen_q |-> !dev_sda_oe)
    else $error("device drove data line before any start");
  a_addr_silent: assert property (first_q && nbit_q < 4'h8 |-> !dev_sda_oe)
    else $error("device drove data line during address bits");
  a_busy_release: assert property (nv_busy |-> !dev_sda_oe)
    else $error("device drove data line while programming");
  a_busy_bound: assert property (nv_busy |-> busy_cnt_q <= NV_CYC)
    else $error("program cycle too long");
  a_busy_at_stop: assert property ($rose(nv_busy) |-> stop_age_q <= 8'd12)
    else $error("program cycle began without a stop");
  a_tap_settle: assert property ($changed(wiper_tap) |->
    set_age_q >= 12'd1240 && set_age_q <= 12'd2500 && wiper_tap == wiper_setting_reg)
    else $error("wiper output moved outside settle window");
  a_tap_follow: assert property (set_age_q == 12'd2500 |-> wiper_tap == wiper_setting_reg)
    else $error("wiper output did not follow register");
  a_host_drain: assert property ((host_scl_oe || host_sda_oe) |-> !host_scl_o && !host_sda_o)
    else $error("host drives a bus line high");
endmodule

// >>> pot_i2c_slave_access_select_bench.sv
`timescale 1ns/10ps
`include "pis_defines.svh"
module pot_i2c_slave_access_select_bench;
  typedef struct packed {logic [11:0] cmd; logic [31:0] mask; logic [31:0] exp;} pis_row_t;
  // arbitrary type value
  localparam logic [4:0] DEV_TYPE = 5'h13;
  localparam int NV = 1000;
  localparam logic [11:0] S = 12'h100, P = 12'h200, RD = 12'h400, NK = 12'h800;
  localparam logic [11:0] AW = {4'h0, DEV_TYPE, 2'b10, 1'b0};
  localparam logic [11:0] ARD = {4'h0, DEV_TYPE, 2'b10, 1'b1};
  localparam logic [11:0] AX = {4'h0, DEV_TYPE, 2'b01, 1'b0};
  localparam logic [11:0] AY = {4'h0, ~DEV_TYPE, 2'b10, 1'b0};
  localparam logic [31:0] MN = 32'h2, MR = 32'hff00, NA = 32'h2, Z = 32'h0;
  localparam pis_row_t ROWS [18] = '{
    '{S|AW, MN, Z}, '{12'h002, MN, Z}, '{P|12'h080, MN, Z}, '{S|AW, MN, Z},
    '{12'h000, MN, Z}, '{P|12'h0b7, MN, Z}, '{S|ARD, MN, Z}, '{RD, MR, 32'h3700},
    '{RD|NK|P, MR, 32'h3700}, '{S|P|AX, MN, NA}, '{S|P|AY, MN, NA}, '{S|AW, MN, Z},
    '{12'h002, MN, Z}, '{P|12'h000, MN, Z}, '{S|AW, MN, Z}, '{12'h000, MN, Z},
    '{P|12'h0aa, MN, Z}, '{S|P|AW, MN, NA}};

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, nv_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [6:0] wiper_tap, wiper_setting_reg, stored_setting_reg;
  logic [7:0] register_selector;
  int n_mismatch, n_compared;

  pis_if i_pis_if ();
  pis_device #(.TYPE_ID(DEV_TYPE), .NV_CYC(NV), .STORED_INIT(7'h15)) i_pis_device (
    .pclk(pclk), .presetn(presetn), .bus(i_pis_if), .strap_addr_hi(1'b1),
    .strap_addr_lo(1'b0), .wiper_tap(wiper_tap), .wiper_setting_reg(wiper_setting_reg),
    .stored_setting_reg(stored_setting_reg), .register_selector(register_selector),
    .nv_busy(nv_busy));
  pis_host #(.POWERUP_CYC(20)) i_pis_host (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus(i_pis_if));
  pis_props #(.NV_CYC(NV)) i_pis_props (
    .pclk(pclk), .presetn(presetn), .host_scl_o(i_pis_if.host_scl_o),
    .host_scl_oe(i_pis_if.host_scl_oe), .host_sda_o(i_pis_if.host_sda_o),
    .host_sda_oe(i_pis_if.host_sda_oe), .dev_sda_o(i_pis_if.dev_sda_o),
    .dev_sda_oe(i_pis_if.dev_sda_oe), .scl(i_pis_if.scl), .sda(i_pis_if.sda),
    .nv_busy(nv_busy), .wiper_setting_reg(wiper_setting_reg), .wiper_tap(wiper_tap));

  always #2 pclk = ~pclk;

  // ************************************************
  // tasks
  // ************************************************
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic timeout();
    n_mismatch++;
    $display("MISMATCH at %0t: wait ran out", $time);
    conclude();
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) timeout();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic stat(output logic [31:0] st);
    logic err;
    apb(1'b0, `PIS_REG_STATUS, 32'h0, st, err);
  endtask

  task automatic wait_idle();
    logic [31:0] st;
    int n;
    for (n = 0; n < 3000; n++) begin
      stat(st);
      if (st[0] === 1'b0) break;
    end
    if (n == 3000) timeout();
  endtask

  task automatic run(input logic [11:0] c);
    logic [31:0] rd;
    logic err;
    apb(1'b1, `PIS_REG_CMD, {20'h0, c}, rd, err);
    wait_idle();
  endtask

  // ************************************************
  // sequence
  // ************************************************
  initial begin
    logic [31:0] st, rd;
    logic err;
    int i;
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'(register_selector), 32'h80);
    chk(32'(wiper_tap), 32'h40);
    chk(32'(nv_busy), 32'h0);
    stat(st);
    chk(32'(st[2]), 32'h0);
    // power-up hold-off ends some cycles later, poll for it
    for (i = 0; i < 20; i++) begin
      stat(st);
      if (st[2] === 1'b1) break;
    end
    chk(32'(st[2]), 32'h1);
    repeat (2600) @(posedge pclk);
    chk(32'(wiper_tap), 32'h15);
    for (i = 0; i < 18; i++) begin
      run(ROWS[i].cmd);
      stat(st);
      chk(st & ROWS[i].mask, ROWS[i].exp);
    end
    for (i = 0; i < 20; i++) begin
      run(S|P|AW);
      stat(st);
      if (st[1] === 1'b0) break;
    end
    chk(32'(st[1]), 32'h0);
    chk(32'(stored_setting_reg), 32'h2a);
    chk(32'(wiper_setting_reg), 32'h2a);
    run(S|AW);
    run(12'h002);
    run(S|AW);
    run(12'h002);
    run(P|12'h080);
    chk(32'(register_selector), 32'h80);
    run(S|AW);
    run(12'h000);
    run(S|ARD);
    run(RD|NK|P);
    stat(st);
    chk(st & MR, 32'h2a00);
    repeat (2600) @(posedge pclk);
    chk(32'(wiper_tap), 32'h2a);
    apb(1'b0, 12'h00c, 32'h0, rd, err);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, `PIS_REG_STATUS, 32'hffff_ffff, rd, err);
    chk(32'(err), 32'h0);
    conclude();
  end
endmodule
